// ===== logic/smw_top.sv
`timescale 1ns/100ps
module smw_top (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address channel.
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data channel.
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response channel.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address channel.
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data channel.
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Host-side mailbox port.
   input wire logic host_inbound_wr,
   input wire logic [7:0] host_inbound_data,
   input wire logic host_outbound_clr,
   input wire logic [7:0] host_outbound_mask,
   output logic [7:0] host_inbound_byte,
   output logic [7:0] host_outbound_byte,
   output logic host_event,
   // Host data-port access request.
   input wire logic [15:0] host_window_offset,
   input wire logic host_data_rd,
   input wire logic host_data_wr,
   output logic [31:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   // Controller interrupt.
   output logic irq
);
   import smw_pkg::*;

   // Register state.
   logic [31:0] base0_q;
   logic [15:0] rdlim0_q;
   logic [15:0] wrlim0_q;
   logic [SMW_IRQ_W-1:0] irq_status_q;
   logic [SMW_IRQ_W-1:0] irq_enable_q;
   logic host_flag_q;
   logic [31:0] mem_addr_q;
   logic mem_rd_q;
   logic mem_wr_q;
   logic irq_q;

   // Bus channel state.
   logic aw_full_q;
   logic [31:0] aw_addr_q;
   logic w_full_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   // Ready flags live in flops of their own, so the ports see no gate.
   logic awready_q;
   logic wready_q;
   logic arready_q;

   // Mailbox storage wires.
   logic [7:0] inbound_val;
   logic [7:0] outbound_val;
   logic inbound_evt;
   logic outbound_evt;

   // Address forming wires.
   logic region0;
   logic [31:0] region_addr;
   logic read_ok;
   logic write_ok;

   // A write is performed once both address and data are held.
   // It waits while a response stands, so each write gets one answer.
   wire logic wr_fire = aw_full_q && w_full_q && !bvalid_q;
   wire logic [SMW_ADDR_W-1:0] wr_idx = aw_addr_q[SMW_ADDR_W+1:2];
   wire logic [SMW_ADDR_W-1:0] rd_idx = s_axi_araddr[SMW_ADDR_W+1:2];
   wire logic rd_take = s_axi_arvalid && !rvalid_q;

   // Write address decoding.
   // register offsets
   wire logic wr_in = wr_idx == SMW_ADDR_W'(SMW_IDX_INBOUND);
   wire logic wr_out = wr_idx == SMW_ADDR_W'(SMW_IDX_OUTBOUND);
   wire logic wr_base = wr_idx == SMW_ADDR_W'(SMW_IDX_BASE0);
   wire logic wr_rdl = wr_idx == SMW_ADDR_W'(SMW_IDX_RDLIM0);
   wire logic wr_wrl = wr_idx == SMW_ADDR_W'(SMW_IDX_WRLIM0);
   wire logic wr_ien = wr_idx == SMW_ADDR_W'(SMW_IDX_IRQ_ENABLE);
   wire logic wr_icl = wr_idx == SMW_ADDR_W'(SMW_IDX_IRQ_CLEAR);
   wire logic wr_hst = wr_idx == SMW_ADDR_W'(SMW_IDX_HOST_STATUS);
   wire logic wr_hit = wr_in || wr_out || wr_base || wr_rdl || wr_wrl ||
      wr_ien || wr_icl || wr_hst;

   // Byte-lane merge of the written word.
   wire logic [31:0] strb_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
      {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   wire logic [31:0] wmask = w_data_q & strb_mask;
   wire logic [31:0] base0_d = ((base0_q & ~strb_mask) | wmask) &
      SMW_BASE_MASK;
   wire logic [15:0] rdlim0_d = ((rdlim0_q & ~strb_mask[15:0]) |
      wmask[15:0]) & SMW_LIMIT_MASK;
   wire logic [15:0] wrlim0_d = ((wrlim0_q & ~strb_mask[15:0]) |
      wmask[15:0]) & SMW_LIMIT_MASK;

   // Controller-side mailbox strobes.
   // controller clears inbound
   wire logic ec_in_clr = wr_fire && wr_in && w_strb_q[0];
   wire logic ec_out_wr = wr_fire && wr_out && w_strb_q[0];

   // Read data selection.
   wire logic [31:0] rd_mux =
      (rd_idx == SMW_ADDR_W'(SMW_IDX_INBOUND)) ? {24'h00_0000, inbound_val} :
      (rd_idx == SMW_ADDR_W'(SMW_IDX_OUTBOUND)) ? {24'h00_0000, outbound_val} :
      (rd_idx == SMW_ADDR_W'(SMW_IDX_BASE0)) ? base0_q :
      (rd_idx == SMW_ADDR_W'(SMW_IDX_RDLIM0)) ? {16'h0000, rdlim0_q} :
      (rd_idx == SMW_ADDR_W'(SMW_IDX_WRLIM0)) ? {16'h0000, wrlim0_q} :
      (rd_idx == SMW_ADDR_W'(SMW_IDX_IRQ_STATUS)) ?
         {30'h0000_0000, irq_status_q} :
      (rd_idx == SMW_ADDR_W'(SMW_IDX_IRQ_ENABLE)) ?
         {30'h0000_0000, irq_enable_q} :
      (rd_idx == SMW_ADDR_W'(SMW_IDX_HOST_STATUS)) ?
         {31'h0000_0000, host_flag_q} : 32'h0000_0000;
   wire logic rd_hit = (rd_idx == SMW_ADDR_W'(SMW_IDX_INBOUND)) ||
      (rd_idx == SMW_ADDR_W'(SMW_IDX_OUTBOUND)) ||
      (rd_idx == SMW_ADDR_W'(SMW_IDX_BASE0)) ||
      (rd_idx == SMW_ADDR_W'(SMW_IDX_RDLIM0)) ||
      (rd_idx == SMW_ADDR_W'(SMW_IDX_WRLIM0)) ||
      (rd_idx == SMW_ADDR_W'(SMW_IDX_IRQ_STATUS)) ||
      (rd_idx == SMW_ADDR_W'(SMW_IDX_IRQ_ENABLE)) ||
      (rd_idx == SMW_ADDR_W'(SMW_IDX_HOST_STATUS));

   // Interrupt status next value; a new event wins over a clear.
   wire logic [SMW_IRQ_W-1:0] irq_evt = {outbound_evt, inbound_evt};
   wire logic [SMW_IRQ_W-1:0] irq_clr =
      (wr_fire && wr_icl) ? w_data_q[SMW_IRQ_W-1:0] : '0;
   wire logic [SMW_IRQ_W-1:0] irq_status_d =
      (irq_status_q & ~irq_clr) | irq_evt;
   // The host flag is served by a host clear or a controller write of one.
   wire logic host_flag_clr = host_outbound_clr ||
      (wr_fire && wr_hst && w_data_q[0]);

   // The inbound mailbox: host loads, controller clears.
   // host write event
   smw_mailbox #(.WIDTH(8)) u_inbound (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(host_inbound_wr),
      .load_data(host_inbound_data),
      .clear(ec_in_clr),
      .clear_mask(w_data_q[7:0]),
      .value(inbound_val),
      .event_pulse(inbound_evt)
   );

   // The outbound mailbox: controller loads, host clears.
   // controller write event
   smw_mailbox #(.WIDTH(8)) u_outbound (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(ec_out_wr),
      .load_data(w_data_q[7:0]),
      .clear(host_outbound_clr),
      .clear_mask(host_outbound_mask),
      .value(outbound_val),
      .event_pulse(outbound_evt)
   );

   // Region 0 address and bound checks.
   smw_region_addr u_region (
      .base(base0_q),
      .read_limit(rdlim0_q),
      .write_limit(wrlim0_q),
      .offset(host_window_offset),
      .region0(region0),
      .mem_addr(region_addr),
      .read_ok(read_ok),
      .write_ok(write_ok)
   );

   // Write channel capture; each channel is accepted independently.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         awready_q <= 1'b1;
         aw_addr_q <= SMW_RESET_VAL;
         w_full_q <= 1'b0;
         wready_q <= 1'b1;
         w_data_q <= SMW_RESET_VAL;
         w_strb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            awready_q <= 1'b0;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_full_q <= 1'b0;
            awready_q <= 1'b1;
         end
         if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            wready_q <= 1'b0;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_full_q <= 1'b0;
            wready_q <= 1'b1;
         end
      end
   end

   // Write response; unmapped addresses answer with a slave error.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= SMW_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? SMW_RESP_OKAY : SMW_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Read channel: one cycle from address to data.
   // The address is decoded straight from the bus, so it must stay steady
   // while arvalid is high, which the bus rules ask of the master anyway.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
         rdata_q <= SMW_RESET_VAL;
         rresp_q <= SMW_RESP_OKAY;
      end else if (rd_take) begin
         rvalid_q <= 1'b1;
         arready_q <= 1'b0;
         rdata_q <= rd_mux;
         rresp_q <= rd_hit ? SMW_RESP_OKAY : SMW_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // Region and interrupt enable registers, zero after reset.
   // reset to zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         base0_q <= SMW_RESET_VAL;
         rdlim0_q <= 16'h0000;
         wrlim0_q <= 16'h0000;
         irq_enable_q <= '0;
      end else if (wr_fire) begin
         if (wr_base)
            base0_q <= base0_d;
         if (wr_rdl)
            rdlim0_q <= rdlim0_d;
         if (wr_wrl)
            wrlim0_q <= wrlim0_d;
         if (wr_ien)
            irq_enable_q <= w_data_q[SMW_IRQ_W-1:0];
      end
   end

   // Sticky event flags; the host flag is served by a host clear or a controller write of one.
   // events held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_q <= '0;
         host_flag_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         irq_status_q <= irq_status_d;
         irq_q <= |(irq_status_d & irq_enable_q);
         if (outbound_evt)
            host_flag_q <= 1'b1;
         else if (host_flag_clr)
            host_flag_q <= 1'b0;
      end
   end

   // Registered memory request from the host data port.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mem_addr_q <= SMW_RESET_VAL;
         mem_rd_q <= 1'b0;
         mem_wr_q <= 1'b0;
      end else begin
         mem_addr_q <= region0 ? region_addr : mem_addr_q;
         mem_rd_q <= host_data_rd && read_ok;
         mem_wr_q <= host_data_wr && write_ok;
      end
   end

   // Output drive.
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign host_inbound_byte = inbound_val;
   assign host_outbound_byte = outbound_val;
   assign host_event = host_flag_q;
   assign mem_addr = mem_addr_q;
   assign mem_rd = mem_rd_q;
   assign mem_wr = mem_wr_q;
   assign irq = irq_q;
endmodule

// ===== pkg/smw_pkg.sv
package smw_pkg;
   // Word indices relative to the block base, one 32-bit register per index.
   localparam logic [31:0] SMW_BLOCK_BASE = 32'h400F_0100;
   localparam logic [7:0] SMW_IDX_INBOUND = 8'h00;
   localparam logic [7:0] SMW_IDX_OUTBOUND = 8'h01;
   localparam logic [7:0] SMW_IDX_BASE0 = 8'h04;
   localparam logic [7:0] SMW_IDX_RDLIM0 = 8'h08;
   localparam logic [7:0] SMW_IDX_WRLIM0 = 8'h0A;
   localparam logic [7:0] SMW_IDX_IRQ_STATUS = 8'h20;
   localparam logic [7:0] SMW_IDX_IRQ_ENABLE = 8'h21;
   localparam logic [7:0] SMW_IDX_IRQ_CLEAR = 8'h22;
   localparam logic [7:0] SMW_IDX_HOST_STATUS = 8'h23;
   // Register byte addresses are four times the index.
   localparam int SMW_ADDR_W = 10;
   // Interrupt status bit positions.
   localparam int SMW_IRQ_INBOUND_BIT = 0;
   localparam int SMW_IRQ_OUTBOUND_BIT = 1;
   localparam int SMW_IRQ_W = 2;
   // Region selection and bound fields of the host window offset.
   localparam int SMW_REGION_SEL_BIT = 15;
   localparam int SMW_BOUND_HI = 14;
   localparam int SMW_BOUND_LO = 2;
   localparam logic [31:0] SMW_BASE_MASK = 32'hFFFF_FFFC;
   localparam logic [15:0] SMW_LIMIT_MASK = 16'h7FFC;
   localparam logic [31:0] SMW_RESET_VAL = 32'h0000_0000;
   localparam logic [1:0] SMW_RESP_OKAY = 2'b00;
   localparam logic [1:0] SMW_RESP_SLVERR = 2'b10;
endpackage

// ===== logic/smw_mailbox.sv
`timescale 1ns/100ps
// One byte mailbox: the writer side loads it and raises an event flag,
// the reader side clears bits written with one.
module smw_mailbox #(
   parameter int WIDTH = 8
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Loading side.
   input wire logic load,
   input wire logic [WIDTH-1:0] load_data,
   // Clearing side.
   input wire logic clear,
   input wire logic [WIDTH-1:0] clear_mask,
   // Shared storage and event.
   output logic [WIDTH-1:0] value,
   output logic event_pulse
);
   initial begin
      if (WIDTH < 1) $error("smw_mailbox: WIDTH must be positive.");
   end

   // Load wins over a clear in the same cycle, so no message is lost.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         value <= '0;
         event_pulse <= 1'b0;
      end else begin
         event_pulse <= load;
         if (load)
            value <= load_data;
         else if (clear)
            value <= value & ~clear_mask;
      end
   end
endmodule

// ===== logic/smw_region_addr.sv
`timescale 1ns/100ps
// Region 0 address former with read and write bound checks.
module smw_region_addr (
   // Programmed region settings.
   input wire logic [31:0] base,
   input wire logic [15:0] read_limit,
   input wire logic [15:0] write_limit,
   // Host window offset.
   input wire logic [15:0] offset,
   // Results.
   output logic region0,
   output logic [31:0] mem_addr,
   output logic read_ok,
   output logic write_ok
);
   import smw_pkg::*;
   wire logic [12:0] offs_w = offset[SMW_BOUND_HI:SMW_BOUND_LO];
   // Region selection and address sum.
   // bit 15 select
   assign region0 = ~offset[SMW_REGION_SEL_BIT];
   assign mem_addr = (base & SMW_BASE_MASK) + {16'h0000, offset};
   assign read_ok = region0 && (offs_w < read_limit[SMW_BOUND_HI:SMW_BOUND_LO]);
   assign write_ok = region0 &&
      (offs_w < write_limit[SMW_BOUND_HI:SMW_BOUND_LO]);
endmodule

// ===== test/smw_chk.sv
`timescale 1ns/100ps
// Port-level watch over the mailbox and window address unit.
module smw_chk (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus handshakes.
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // Host mailbox port.
   input wire logic host_inbound_wr,
   input wire logic [7:0] host_inbound_data,
   input wire logic host_outbound_clr,
   input wire logic [7:0] host_outbound_mask,
   input wire logic [7:0] host_inbound_byte,
   input wire logic [7:0] host_outbound_byte,
   input wire logic host_event,
   // Host data port.
   input wire logic [15:0] host_window_offset,
   input wire logic host_data_rd,
   input wire logic host_data_wr,
   input wire logic [31:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Nothing offered or held on the write side, so no register write can
   // land next cycle and a host action is the only cause of change.
   sequence bus_idle;
      !s_axi_awvalid && !s_axi_wvalid && s_axi_awready && s_axi_wready;
   endsequence
   // Address and data of one write taken at the same edge.
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   a_inbound_load: assert property (
      host_inbound_wr |=> host_inbound_byte == $past(host_inbound_data))
      else $error("inbound mailbox missed host byte");
   a_inbound_keep: assert property (
      (bus_idle ##0 !host_inbound_wr) |=> $stable(host_inbound_byte))
      else $error("inbound mailbox changed on its own");
   a_outbound_clr: assert property (
      (bus_idle ##0 host_outbound_clr) |=> host_outbound_byte ==
      ($past(host_outbound_byte) & ~$past(host_outbound_mask)))
      else $error("outbound mailbox clear wrong");
   a_event_drop: assert property (
      (bus_idle ##1 bus_idle ##0 host_outbound_clr) |=> !host_event)
      else $error("host event not cleared");
   a_event_hold: assert property (
      (bus_idle ##0 host_event && !host_outbound_clr) |=> host_event)
      else $error("host event lost before service");
   a_region_sel: assert property (
      (host_data_rd || host_data_wr) && host_window_offset[15]
      |=> !mem_rd && !mem_wr)
      else $error("access outside region 0 reached memory");
   a_addr_hold: assert property (
      host_window_offset[15] |=> $stable(mem_addr))
      else $error("memory address moved for region 1");
   a_no_access: assert property (
      !host_data_rd && !host_data_wr |=> !mem_rd && !mem_wr)
      else $error("memory access without request");
   a_write_answer: assert property (
      wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
endmodule

// ===== test/smw_host_model.sv
`timescale 1ns/100ps
// Host side: mailbox writes and clears, and data-port requests.
module smw_host_model (
   // Clock.
   input wire logic aclk,
   // Mailbox requests.
   output logic host_inbound_wr,
   output logic [7:0] host_inbound_data,
   output logic host_outbound_clr,
   output logic [7:0] host_outbound_mask,
   // Data-port requests.
   output logic [15:0] host_window_offset,
   output logic host_data_rd,
   output logic host_data_wr
);
   // Idle levels; released buses show the inverse so stale data is caught.
   initial begin
      host_inbound_wr = 1'b0;
      host_inbound_data = 8'h00;
      host_outbound_clr = 1'b0;
      host_outbound_mask = 8'h00;
      host_window_offset = 16'hFFFF;
      host_data_rd = 1'b0;
      host_data_wr = 1'b0;
   end
   // One-cycle host write of the inbound mailbox.
   task send(input logic [7:0] d);
      @(posedge aclk);
      host_inbound_wr <= 1'b1;
      host_inbound_data <= d;
      @(posedge aclk);
      host_inbound_wr <= 1'b0;
      host_inbound_data <= ~d;
   endtask
   task clear(input logic [7:0] m);
      @(posedge aclk);
      host_outbound_clr <= 1'b1;
      host_outbound_mask <= m;
      @(posedge aclk);
      host_outbound_clr <= 1'b0;
      host_outbound_mask <= ~m;
   endtask
   // One-cycle data-port read or write at a window offset.
   task access(input logic [15:0] off, input logic w);
      @(posedge aclk);
      host_window_offset <= off;
      host_data_rd <= !w;
      host_data_wr <= w;
      @(posedge aclk);
      host_data_rd <= 1'b0;
      host_data_wr <= 1'b0;
      host_window_offset <= ~off;
   endtask
endmodule

// ===== test/shared_memory_mailbox_ec_side_test.sv
`timescale 1ns/100ps
module shared_memory_mailbox_ec_side_test;
   import smw_pkg::*;
   logic aclk, aresetn, irq, host_event, mem_rd, mem_wr;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [31:0] mem_addr;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, host_inbound_wr, host_outbound_clr;
   logic [7:0] host_inbound_data, host_outbound_mask;
   logic [7:0] host_inbound_byte, host_outbound_byte;
   logic [15:0] host_window_offset;
   logic host_data_rd, host_data_wr;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   smw_top uut (.*);
   smw_host_model host (.*);
   // Free-running 125 MHz clock.
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // Hang guard: the whole run needs well under a thousand cycles.
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         wrap_up();
      end
   end
   task wrap_up;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   function logic [31:0] ra(input logic [7:0] i);
      return {22'h0, i, 2'b00};
   endfunction
   task tick(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask
   // Register write; each channel is released at the edge it is taken.
   task wr(input logic [31:0] a, input logic [31:0] d,
           input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_awvalid && !s_axi_awready ||
                 s_axi_wvalid && !s_axi_wready);
      while (!s_axi_bvalid) @(posedge aclk);
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(er));
   endtask
   // Register read; data is judged only when an OKAY answer is expected.
   task rd(input logic [31:0] a, input logic [31:0] ed,
           input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge aclk);
      s_axi_rready <= 1'b0;
      chk(32'(s_axi_rresp), 32'(er));
      if (er == SMW_RESP_OKAY) chk(s_axi_rdata, ed);
   endtask
   task acc(input logic [15:0] off, input logic w, input logic [1:0] e);
      host.access(off, w);
      #1;
      chk(32'({mem_wr, mem_rd}), 32'(e));
   endtask
   task t_reset;
      rd(ra(SMW_IDX_INBOUND), 32'h0, SMW_RESP_OKAY);
      rd(ra(SMW_IDX_OUTBOUND), 32'h0, SMW_RESP_OKAY);
      rd(ra(SMW_IDX_BASE0), 32'h0, SMW_RESP_OKAY);
      chk(32'(irq), 32'h0);
      rd(32'h0000_03FC, 32'h0, SMW_RESP_SLVERR);
      wr(32'h0000_03FC, 32'hFFFF_FFFF, SMW_RESP_SLVERR);
      $display("reset test done");
   endtask
   task t_inbound;
      wr(ra(SMW_IDX_IRQ_ENABLE), 32'h3, SMW_RESP_OKAY);
      host.send(8'hA5);
      tick(3);
      chk(32'(host_inbound_byte), 32'hA5);
      rd(ra(SMW_IDX_INBOUND), 32'hA5, SMW_RESP_OKAY);
      chk(32'(irq), 32'h1);
      rd(ra(SMW_IDX_IRQ_STATUS), 32'h1, SMW_RESP_OKAY);
      wr(ra(SMW_IDX_INBOUND), 32'h21, SMW_RESP_OKAY);
      rd(ra(SMW_IDX_INBOUND), 32'h84, SMW_RESP_OKAY);
      chk(32'(host_inbound_byte), 32'h84);
      wr(ra(SMW_IDX_IRQ_CLEAR), 32'h1, SMW_RESP_OKAY);
      tick(2);
      chk(32'(irq), 32'h0);
      wr(ra(SMW_IDX_IRQ_ENABLE), 32'h0, SMW_RESP_OKAY);
      host.send(8'h0F);
      tick(3);
      chk(32'(irq), 32'h0);
      rd(ra(SMW_IDX_IRQ_STATUS), 32'h1, SMW_RESP_OKAY);
      wr(ra(SMW_IDX_IRQ_CLEAR), 32'h1, SMW_RESP_OKAY);
      $display("inbound test done");
   endtask
   task t_outbound;
      wr(ra(SMW_IDX_OUTBOUND), 32'h3C, SMW_RESP_OKAY);
      tick(3);
      chk(32'(host_outbound_byte), 32'h3C);
      chk(32'(host_event), 32'h1);
      rd(ra(SMW_IDX_IRQ_STATUS), 32'h2, SMW_RESP_OKAY);
      host.clear(8'h14);
      tick(1);
      chk(32'(host_outbound_byte), 32'h28);
      chk(32'(host_event), 32'h0);
      rd(ra(SMW_IDX_OUTBOUND), 32'h28, SMW_RESP_OKAY);
      wr(ra(SMW_IDX_IRQ_ENABLE), 32'h2, SMW_RESP_OKAY);
      tick(1);
      chk(32'(irq), 32'h1);
      wr(ra(SMW_IDX_OUTBOUND), 32'h5A, SMW_RESP_OKAY);
      tick(1);
      chk(32'(host_event), 32'h1);
      chk(32'(host_outbound_byte), 32'h5A);
      wr(ra(SMW_IDX_HOST_STATUS), 32'h1, SMW_RESP_OKAY);
      chk(32'(host_event), 32'h0);
      wr(ra(SMW_IDX_IRQ_STATUS), 32'h3, SMW_RESP_SLVERR);
      wr(ra(SMW_IDX_IRQ_CLEAR), 32'h2, SMW_RESP_OKAY);
      chk(32'(irq), 32'h0);
      rd(ra(SMW_IDX_IRQ_CLEAR), 32'h0, SMW_RESP_SLVERR);
      rd(ra(SMW_IDX_IRQ_STATUS), 32'h0, SMW_RESP_OKAY);
      wr(ra(SMW_IDX_IRQ_ENABLE), 32'h0, SMW_RESP_OKAY);
      $display("outbound test done");
   endtask
   task t_region;
      wr(ra(SMW_IDX_BASE0), 32'h1234_5677, SMW_RESP_OKAY);
      rd(ra(SMW_IDX_BASE0), 32'h1234_5674, SMW_RESP_OKAY);
      wr(ra(SMW_IDX_RDLIM0), 32'h10, SMW_RESP_OKAY);
      wr(ra(SMW_IDX_WRLIM0), 32'h8, SMW_RESP_OKAY);
      acc(16'h000C, 1'b0, 2'b01);
      chk(mem_addr, 32'h1234_5680);
      acc(16'h0010, 1'b0, 2'b00);
      acc(16'h0008, 1'b1, 2'b00);
      acc(16'h0004, 1'b1, 2'b10);
      chk(mem_addr, 32'h1234_5678);
      acc(16'h800C, 1'b0, 2'b00);
      chk(mem_addr, 32'h1234_5678);
      $display("region test done");
   endtask
   // A reset in mid-run must wipe mailboxes and region settings alike.
   task t_rearm;
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      tick(1);
      chk(32'(host_inbound_byte), 32'h0);
      chk(32'(host_outbound_byte), 32'h0);
      chk(32'(host_event), 32'h0);
      rd(ra(SMW_IDX_BASE0), 32'h0, SMW_RESP_OKAY);
      rd(ra(SMW_IDX_RDLIM0), 32'h0, SMW_RESP_OKAY);
      $display("rearm test done");
   endtask
   // Reset for ten cycles, then the scenarios in turn.
   initial begin
      aresetn = 1'b0;
      s_axi_awaddr = 32'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      s_axi_araddr = 32'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
      {s_axi_arvalid, s_axi_rready} = 2'b00;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_inbound();
      t_outbound();
      t_region();
      t_rearm();
      wrap_up();
   end
endmodule
bind smw_top smw_chk chk (.*);
